//--- include/sci_pkg.sv
// Constants and types shared by the command intake block
package sci_pkg;
  localparam int unsigned ADDR_HIGH_W   = 5;
  localparam logic [4:0]  ADDR_HIGH     = 5'h0A;  // Common high-order address bits, arbitrary value
  localparam int unsigned OP_W          = 3;
  localparam int unsigned VAL_W         = 5;
  localparam int unsigned OP_POS        = 5;
  localparam logic [2:0]  OP_MARGIN     = 3'h1;
  localparam logic [2:0]  OP_UNUSED     = 3'h2;
  localparam logic [2:0]  OP_WATCHDOG   = 3'h3;
  localparam logic [4:0]  VAL_ARM       = 5'h00;
  localparam logic [2:0]  BIT_CNT_RST   = 3'h7;
  localparam logic [7:0]  SHIFT_RST     = 8'h00;
  localparam logic [1:0]  SEL_ID_RST    = 2'h0;
  localparam int unsigned SYNC_STAGES   = 2;

  typedef enum logic [2:0] {SCI_IDLE, SCI_ADDR, SCI_ADDR_ACK, SCI_DATA, SCI_DATA_ACK, SCI_IGNORE} sci_state_t;
endpackage : sci_pkg

//--- include/sci_cmd_if.sv
// Captured command fields from the link domain to the system domain
interface sci_cmd_if;
  logic       toggle;
  logic [2:0] op;
  logic [4:0] val;
  modport link (output toggle, output op, output val);
  modport sys  (input toggle, input op, input val);
endinterface : sci_cmd_if

//--- logic/sci_cmd_sync.sv
// Toggle crossing that hands a captured command into the system clock domain
module sci_cmd_sync
  import sci_pkg::*;
(
  input  wire logic       mclk_in,
  input  wire logic       resetn_in,
  sci_cmd_if.sys          cmd,
  output logic            valid_out,
  output logic [2:0]      op_out,
  output logic [4:0]      val_out
);
  logic       sync1_r, sync2_r, seen_r;
  logic       valid_nxt;
  logic [2:0] op_nxt;
  logic [4:0] val_nxt;

  always_comb begin
    valid_nxt = sync2_r ^ seen_r;
    op_nxt    = op_out;
    val_nxt   = val_out;
    // Fields are stable long before the toggle lands here
    if (valid_nxt) begin
      op_nxt  = cmd.op;
      val_nxt = cmd.val;
    end
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sync1_r   <= 1'b0;
      sync2_r   <= 1'b0;
      seen_r    <= 1'b0;
      valid_out <= 1'b0;
      op_out    <= 3'h0;
      val_out   <= 5'h00;
    end else begin
      sync1_r   <= cmd.toggle;
      sync2_r   <= sync1_r;
      seen_r    <= sync2_r;
      valid_out <= valid_nxt;
      op_out    <= op_nxt;
      val_out   <= val_nxt;
    end
  end
endmodule : sci_cmd_sync

//--- logic/sci_top.sv
// Two-wire write-only slave that takes in command bytes
module sci_top
  import sci_pkg::*;
(
  input  wire logic       mclk_in,
  input  wire logic       resetn_in,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe_out,
  input  wire logic       clock_select_strap_in,
  input  wire logic       id_strap_in,
  output logic            osc_sync_is_output_out,
  output logic            cmd_valid_out,
  output logic [2:0]      cmd_op_out,
  output logic [4:0]      cmd_val_out,
  output logic            margin_valid_out,
  output logic            watchdog_valid_out,
  output logic [4:0]      action_val_out
);
  sci_cmd_if cmd_bus ();

  // Strap pins in the system domain, caught once the synchroniser has filled
  logic [1:0] strap_s1_r, strap_s2_r, sel_id_r, sel_id_nxt;
  logic [1:0] strap_wait_r, strap_wait_nxt;
  logic       strap_done_r, strap_done_nxt;

  always_comb begin
    sel_id_nxt     = sel_id_r;
    strap_done_nxt = strap_done_r;
    strap_wait_nxt = strap_wait_r;
    if (!strap_done_r) begin
      // Capturing earlier would take the synchroniser's reset value
      if (strap_wait_r == 2'(SYNC_STAGES)) begin
        sel_id_nxt     = strap_s2_r;
        strap_done_nxt = 1'b1;
      end else begin
        strap_wait_nxt = strap_wait_r + 2'h1;
      end
    end
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      strap_s1_r   <= SEL_ID_RST;
      strap_s2_r   <= SEL_ID_RST;
      sel_id_r     <= SEL_ID_RST;
      strap_wait_r <= 2'h0;
      strap_done_r <= 1'b0;
    end else begin
      strap_s1_r   <= {clock_select_strap_in, id_strap_in};
      strap_s2_r   <= strap_s1_r;
      sel_id_r     <= sel_id_nxt;
      strap_wait_r <= strap_wait_nxt;
      strap_done_r <= strap_done_nxt;
    end
  end

  assign osc_sync_is_output_out = sel_id_r[1];

  // The link logic reads sel_id_r as a quasi-static value; it settles
  // within a few system cycles of reset, long before any bus traffic.
  logic sel_id_bit_high, sel_id_bit_low;
  assign sel_id_bit_high = sel_id_r[1];
  assign sel_id_bit_low  = sel_id_r[0];

  // Link domain from here, clocked by the serial clock.
  // Start and stop: SDA edges while SCL is high, each kept as a toggle;
  // the link state acts on them at the next serial clock rise.
  logic start_r, stop_r;

  always_ff @(negedge sda_in or negedge resetn_in) begin
    if (!resetn_in)
      start_r <= 1'b0;
    else if (scl_in)
      start_r <= ~start_r;
  end

  always_ff @(posedge sda_in or negedge resetn_in) begin
    if (!resetn_in)
      stop_r <= 1'b0;
    else if (scl_in)
      stop_r <= ~stop_r;
  end

  // Link state advances on SCL rising edges, the ack drive on falling edges
  sci_state_t state_r, state_nxt;
  logic [2:0] bit_cnt_r, bit_cnt_nxt;
  logic [7:0] shift_r, shift_nxt;
  logic       start_seen_r, start_seen_nxt;
  logic       stop_seen_r, stop_seen_nxt;
  logic       tog_r, tog_nxt;
  logic [2:0] op_r, op_nxt;
  logic [4:0] val_r, val_nxt;
  logic [7:0] byte_in;
  logic       new_start, new_stop;

  assign byte_in   = {shift_r[6:0], sda_in};
  assign new_start = start_r ^ start_seen_r;
  assign new_stop  = stop_r ^ stop_seen_r;

  function automatic logic addr_match(input logic [7:0] b, input logic hi, input logic lo);
    addr_match = (b[7:1] == {ADDR_HIGH, hi, lo});
  endfunction

  always_comb begin
    state_nxt      = state_r;
    bit_cnt_nxt    = bit_cnt_r;
    shift_nxt      = shift_r;
    start_seen_nxt = start_r;
    stop_seen_nxt  = stop_r;
    tog_nxt        = tog_r;
    op_nxt         = op_r;
    val_nxt        = val_r;
    if (new_start) begin
      state_nxt   = SCI_ADDR;
      bit_cnt_nxt = BIT_CNT_RST - 3'h1;
      shift_nxt   = {7'h00, sda_in};
    end else if (new_stop) begin
      state_nxt = SCI_IDLE;
    end else begin
      case (state_r)
        SCI_ADDR, SCI_DATA: begin
          shift_nxt   = byte_in;
          bit_cnt_nxt = bit_cnt_r - 3'h1;
          if (bit_cnt_r == 3'h0) begin
            if (state_r == SCI_DATA) begin
              op_nxt    = byte_in[7:OP_POS];
              val_nxt   = byte_in[VAL_W-1:0];
              tog_nxt   = ~tog_r;
              state_nxt = SCI_DATA_ACK;
            end else if (addr_match(byte_in, sel_id_bit_high, sel_id_bit_low) && !byte_in[0]) begin
              state_nxt = SCI_ADDR_ACK;
            end else begin
              state_nxt = SCI_IGNORE;
            end
          end
        end
        SCI_ADDR_ACK, SCI_DATA_ACK: begin
          state_nxt   = SCI_DATA;
          bit_cnt_nxt = BIT_CNT_RST;
        end
        default: state_nxt = state_r;
      endcase
    end
  end

  always_ff @(posedge scl_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_r      <= SCI_IDLE;
      bit_cnt_r    <= BIT_CNT_RST;
      shift_r      <= SHIFT_RST;
      start_seen_r <= 1'b0;
      stop_seen_r  <= 1'b0;
      tog_r        <= 1'b0;
      op_r         <= 3'h0;
      val_r        <= 5'h00;
    end else begin
      state_r      <= state_nxt;
      bit_cnt_r    <= bit_cnt_nxt;
      shift_r      <= shift_nxt;
      start_seen_r <= start_seen_nxt;
      stop_seen_r  <= stop_seen_nxt;
      tog_r        <= tog_nxt;
      op_r         <= op_nxt;
      val_r        <= val_nxt;
    end
  end

  // Ack is driven across the low phase following the eighth bit
  logic ack_r, ack_nxt;
  always_comb begin
    ack_nxt = ((state_r == SCI_ADDR_ACK) || (state_r == SCI_DATA_ACK)) && !new_stop;
  end

  always_ff @(negedge scl_in or negedge resetn_in) begin
    if (!resetn_in)
      ack_r <= 1'b0;
    else
      ack_r <= ack_nxt;
  end

  assign sda_out    = 1'b0;
  assign sda_oe_out = ack_r;

  assign cmd_bus.toggle = tog_r;
  assign cmd_bus.op     = op_r;
  assign cmd_bus.val    = val_r;

  // System domain
  logic       sys_valid;
  logic [2:0] sys_op;
  logic [4:0] sys_val;

  sci_cmd_sync u_sync (
    .mclk_in   (mclk_in),
    .resetn_in (resetn_in),
    .cmd       (cmd_bus),
    .valid_out (sys_valid),
    .op_out    (sys_op),
    .val_out   (sys_val)
  );

  // Arming tracker: an operation byte acts only after its arming byte
  logic [2:0] armed_op_r, armed_op_nxt;
  logic       armed_r, armed_nxt;
  logic       margin_nxt, watchdog_nxt;
  logic [4:0] action_nxt;

  always_comb begin
    armed_op_nxt = armed_op_r;
    armed_nxt    = armed_r;
    margin_nxt   = 1'b0;
    watchdog_nxt = 1'b0;
    action_nxt   = action_val_out;
    if (sys_valid) begin
      if (armed_r && (sys_op == armed_op_r)) begin
        // Stays armed so a second supply can follow the same arming byte
        margin_nxt   = (sys_op == OP_MARGIN);
        watchdog_nxt = (sys_op == OP_WATCHDOG);
        action_nxt   = sys_val;
      end else if ((sys_val == VAL_ARM) && ((sys_op == OP_MARGIN) || (sys_op == OP_WATCHDOG))) begin
        armed_nxt    = 1'b1;
        armed_op_nxt = sys_op;
      end else begin
        armed_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      armed_op_r         <= 3'h0;
      armed_r            <= 1'b0;
      margin_valid_out   <= 1'b0;
      watchdog_valid_out <= 1'b0;
      action_val_out     <= 5'h00;
    end else begin
      armed_op_r         <= armed_op_nxt;
      armed_r            <= armed_nxt;
      margin_valid_out   <= margin_nxt;
      watchdog_valid_out <= watchdog_nxt;
      action_val_out     <= action_nxt;
    end
  end

  assign cmd_valid_out = sys_valid;
  assign cmd_op_out    = sys_op;
  assign cmd_val_out   = sys_val;
endmodule : sci_top

//--- testbench/sci_chk.sv
// Port assertions for the command intake block
module sci_chk
  import sci_pkg::*;
(
  input wire logic       mclk_in,
  input wire logic       resetn_in,
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe_out,
  input wire logic       clock_select_strap_in,
  input wire logic       id_strap_in,
  input wire logic       osc_sync_is_output_out,
  input wire logic       cmd_valid_out,
  input wire logic [2:0] cmd_op_out,
  input wire logic [4:0] cmd_val_out,
  input wire logic       margin_valid_out,
  input wire logic       watchdog_valid_out,
  input wire logic [4:0] action_val_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);
  property p_od; sda_out == 1'b0; endproperty
  a_od: assert property (p_od) else $error("sda driven high");
  // Ack may cover one serial clock only
  property p_ack; @(posedge scl_in) sda_oe_out |=> !sda_oe_out; endproperty
  a_ack: assert property (p_ack) else $error("ack too long");
  property p_pulse; cmd_valid_out |=> !cmd_valid_out; endproperty
  a_pulse: assert property (p_pulse) else $error("valid not a pulse");
  property p_hold; cmd_valid_out |=> $stable({cmd_op_out, cmd_val_out}) [*3]; endproperty
  a_hold: assert property (p_hold) else $error("fields not held");
  property p_mar;
    margin_valid_out |-> $past(cmd_valid_out) && cmd_op_out == OP_MARGIN && cmd_val_out != VAL_ARM;
  endproperty
  a_mar: assert property (p_mar) else $error("bad margin pulse");
  property p_wd; watchdog_valid_out |-> $past(cmd_valid_out) && cmd_op_out == OP_WATCHDOG; endproperty
  a_wd: assert property (p_wd) else $error("bad watchdog pulse");
  property p_act; (margin_valid_out || watchdog_valid_out) |-> action_val_out == cmd_val_out; endproperty
  a_act: assert property (p_act) else $error("bad action value");
  property p_one; !(margin_valid_out && watchdog_valid_out); endproperty
  a_one: assert property (p_one) else $error("two actions at once");
endmodule // sci_chk

bind sci_top sci_chk sci_chk_inst (.*);

//--- testbench/sci_master.sv
// Two-wire bus master model for the command intake slave
module sci_master (
  output logic      scl_out,
  output logic      sda_out,
  input  wire logic sda_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // Clock stands high between frames
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  task automatic start;
    #8 sda_out = 1'b1;
    #8 scl_out = 1'b1;
    #16 sda_out = 1'b0;
    #16 scl_out = 1'b0;
  endtask
  task automatic bitx(input logic b);
    #8 sda_out = b;
    #8 scl_out = 1'b1;
    #16 scl_out = 1'b0;
  endtask
  // Caller puts direction bit 0 for writes
  task automatic put(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--) bitx(d[i]);
    #8 sda_out = 1'b1;
    #8 scl_out = 1'b1;
    #8 ack = !sda_in;
    #8 scl_out = 1'b0;
  endtask
  task automatic stop;
    #8 sda_out = 1'b0;
    #8 scl_out = 1'b1;
    #16 sda_out = 1'b1;
    #16;
  endtask
endmodule // sci_master

//--- testbench/sci_top_bench.sv
// Self-checking bench for the command intake block
module sci_top_bench;
  import sci_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic       mclk = 1'b0, resetn = 1'b0, cks = 1'b0, ids = 1'b0;
  logic       scl, sda_m, sda_o, sda_oe, osc, cv, mv, wv;
  logic [2:0] op;
  logic [4:0] val, act;
  int         fail_count = 0, num_checks = 0, ncv = 0, nmv = 0, nwv = 0;
  // Pull-up: released line reads high
  wire        sda_w = sda_oe ? (sda_o & sda_m) : sda_m;
  always #50 mclk = ~mclk;
  always @(posedge mclk) begin
    ncv += (cv === 1'b1);
    nmv += (mv === 1'b1);
    nwv += (wv === 1'b1);
  end
  sci_top sci_top_inst (.mclk_in(mclk), .resetn_in(resetn), .scl_in(scl), .sda_in(sda_w),
    .sda_out(sda_o), .sda_oe_out(sda_oe), .clock_select_strap_in(cks), .id_strap_in(ids),
    .osc_sync_is_output_out(osc), .cmd_valid_out(cv), .cmd_op_out(op), .cmd_val_out(val),
    .margin_valid_out(mv), .watchdog_valid_out(wv), .action_val_out(act));
  sci_master sci_master_inst (.scl_out(scl), .sda_out(sda_m), .sda_in(sda_w));
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic rst(input logic c, input logic i);
    @(posedge mclk);
    cks <= c;
    ids <= i;
    resetn <= 1'b0;
    repeat (4) @(posedge mclk);
    resetn <= 1'b1;
    repeat (6) @(posedge mclk);
    ncv = 0;
    nmv = 0;
    nwv = 0;
    chk({cv, mv, wv, act}, 8'h00);
  endtask
  // Gap lets each byte cross to the system clock before the next
  task automatic wr(input logic [7:0] d, input logic ea);
    logic a;
    sci_master_inst.put(d, a);
    repeat (6) @(posedge mclk);
    chk({7'h00, a}, {7'h00, ea});
  endtask
  task automatic cnt(input int c, input int m, input int w);
    chk(8'(ncv), 8'(c));
    chk(8'(nmv), 8'(m));
    chk(8'(nwv), 8'(w));
  endtask
  task automatic t_straps;
    for (int k = 0; k < 4; k++) begin
      rst(k[1], k[0]);
      chk({7'h00, osc}, {7'h00, k[1]});
      sci_master_inst.start();
      wr({ADDR_HIGH, k[1:0] ^ 2'h1, 1'b0}, 1'b0);
      sci_master_inst.start();
      wr({ADDR_HIGH, k[1:0], 1'b0}, 1'b1);
      sci_master_inst.stop();
    end
    $display("test straps done");
  endtask
  task automatic t_read;
    rst(1'b1, 1'b1);
    sci_master_inst.start();
    wr({ADDR_HIGH, 2'h3, 1'b1}, 1'b0);
    wr(8'h25, 1'b0);
    sci_master_inst.stop();
    cnt(0, 0, 0);
    $display("test read done");
  endtask
  task automatic t_cmd;
    rst(1'b0, 1'b1);
    sci_master_inst.start();
    wr({ADDR_HIGH, 2'h1, 1'b0}, 1'b1);
    wr({OP_MARGIN, VAL_ARM}, 1'b1);
    cnt(1, 0, 0);
    wr({OP_MARGIN, 5'h05}, 1'b1);
    cnt(2, 1, 0);
    chk({op, val}, {OP_MARGIN, 5'h05});
    chk({3'h0, act}, 8'h05);
    wr({OP_WATCHDOG, 5'h08}, 1'b1);
    cnt(3, 1, 0);
    wr({OP_WATCHDOG, VAL_ARM}, 1'b1);
    wr({OP_WATCHDOG, 5'h09}, 1'b1);
    cnt(5, 1, 1);
    chk({3'h0, act}, 8'h09);
    wr({OP_UNUSED, 5'h01}, 1'b1);
    wr({OP_WATCHDOG, 5'h0A}, 1'b1);
    cnt(7, 1, 1);
    sci_master_inst.stop();
    sci_master_inst.start();
    wr({ADDR_HIGH, 2'h1, 1'b0}, 1'b1);
    wr({OP_MARGIN, VAL_ARM}, 1'b1);
    wr({OP_MARGIN, 5'h12}, 1'b1);
    sci_master_inst.stop();
    cnt(9, 2, 1);
    chk({3'h0, act}, 8'h12);
    $display("test commands done");
  endtask
  initial begin
    #2000000;
    fail_count++;
    summarize();
  end
  initial begin
    t_straps();
    t_read();
    t_cmd();
    summarize();
  end
endmodule // sci_top_bench
